// ### design/psc_defs.svh
`ifndef PSC_DEFS_SVH
`define PSC_DEFS_SVH

// Register addresses
`define PSC_ADDR_MODE 8'h10
`define PSC_ADDR_REFSEL 8'h11
`define PSC_ADDR_LOCK 8'h12
`define PSC_ADDR_DIVR 8'h13

// Mode register fields
`define PSC_SWLSB_BIT 3
`define PSC_MODE_OFF 4'h0
`define PSC_MODE_DIRECT 4'h1
`define PSC_MODE_SW_LOW 4'h2
`define PSC_MODE_SW_HIGH 4'h3

// Reference select values
`define PSC_REF_DISABLE 4'hf
`define PSC_REF_BAD0 4'hb
`define PSC_REF_BAD1 4'he

// Reset values
`define PSC_MODE_RST 4'h0
`define PSC_DIVR_RST 16'h0000

// Reference divider counts at crystal ticks (4.5 MHz base)
`define PSC_XTAL_KHZ 4500

`endif

// ### design/psc_pkg.sv
package psc_pkg;

    typedef enum logic [1:0] {
        PSC_RUN = 2'b00,
        PSC_VCO_OFF = 2'b01,
        PSC_FULL_OFF = 2'b10
    } psc_state_e;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [15:0] wdata;
    } psc_bus_s;

    typedef struct packed {
        logic out;
        logic oe;
    } psc_pin_s;

endpackage

// ### design/psc_synth_ctrl.sv
`timescale 1ns/100ps
`include "psc_defs.svh"
module psc_synth_ctrl #(
    parameter int NW = 17
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic chip_enable,
    input wire logic watchdog_stack_reset,
    input wire logic clock_stop_exec,
    input wire logic halt_state,
    input wire logic xtal_tick,
    input wire psc_pkg::psc_bus_s bus,
    output logic [3:0] rdata,
    input wire logic low_band_vco_input,
    input wire logic high_band_vco_input,
    output logic low_band_vco_pulldown,
    output logic high_band_vco_pulldown,
    output psc_pkg::psc_pin_s error_out_high,
    output psc_pkg::psc_pin_s error_out_low,
    output logic ref_out,
    output logic div_out
);
    logic [3:0] mode;
    logic [3:0] refsel;
    logic [15:0] divider_value_register;
    logic swallow_lsb_flag;
    logic unlock_flag;
    logic [NW-1:0] div_cnt;
    logic [15:0] ref_cnt;
    logic vco_d;
    logic ref_pulse;
    logic div_pulse;
    logic up_req;
    logic dn_req;
    psc_pkg::psc_state_e state;
    logic [3:0] next_mode;
    logic [3:0] next_refsel;
    logic [15:0] next_divr;
    logic next_swlsb;
    logic next_unlock;
    logic [NW-1:0] next_div_cnt;
    logic [15:0] next_ref_cnt;
    logic next_vco_d;
    logic next_ref_out;
    logic next_div_out;
    logic next_up;
    logic next_dn;
    logic [3:0] next_rdata;
    logic [NW-1:0] n_val;
    logic vco_sel;
    logic [15:0] ref_div;

    // Crystal ticks per reference period
    function automatic logic [15:0] ref_period(input logic [3:0] code);
        case (code)
            4'h0: ref_period = 16'h0e10;
            4'h1: ref_period = 16'h0708;
            4'h2: ref_period = 16'h0384;
            4'h3: ref_period = 16'h01c2;
            4'h4: ref_period = 16'h02d0;
            4'h5: ref_period = 16'h0168;
            4'h6: ref_period = 16'h00b4;
            4'h7: ref_period = 16'h005a;
            4'h8: ref_period = 16'h05dc;
            4'h9: ref_period = 16'h01f4;
            4'ha: ref_period = 16'h00fa;
            4'hc: ref_period = 16'h1194;
            4'hd: ref_period = 16'h00e1;
            default: ref_period = 16'h0000;
        endcase
    endfunction

    // Division mode field only; bit 3 carries the swallow LSB
    function automatic logic [3:0] div_mode(input logic [3:0] m);
        div_mode = {2'b00, m[1:0]};
    endfunction

    always_comb begin
        if (!chip_enable || refsel == `PSC_REF_DISABLE || refsel == `PSC_REF_BAD0
            || refsel == `PSC_REF_BAD1) begin
            state = psc_pkg::PSC_FULL_OFF;
        end else if (div_mode(mode) == `PSC_MODE_OFF) begin
            state = psc_pkg::PSC_VCO_OFF;
        end else begin
            state = psc_pkg::PSC_RUN;
        end
    end

    always_comb begin
        case (div_mode(mode))
            `PSC_MODE_SW_HIGH: begin
                vco_sel = high_band_vco_input & (state == psc_pkg::PSC_RUN);
            end
            `PSC_MODE_DIRECT,
            `PSC_MODE_SW_LOW: begin
                vco_sel = low_band_vco_input & (state == psc_pkg::PSC_RUN);
            end
            default: vco_sel = 1'b0;
        endcase
        if (div_mode(mode) == `PSC_MODE_DIRECT) begin
            n_val = NW'({5'h00, divider_value_register[15:4]});
        end else begin
            n_val = NW'({divider_value_register, swallow_lsb_flag});
        end
        ref_div = ref_period(refsel);
        low_band_vco_pulldown = (state != psc_pkg::PSC_RUN)
            || div_mode(mode) == `PSC_MODE_SW_HIGH;
        high_band_vco_pulldown = (state != psc_pkg::PSC_RUN)
            || div_mode(mode) != `PSC_MODE_SW_HIGH;
    end

    assign div_pulse = vco_sel & ~vco_d;
    assign ref_pulse = xtal_tick && ref_cnt == 16'd0 && state != psc_pkg::PSC_FULL_OFF;

    always_comb begin
        next_mode = mode;
        next_refsel = refsel;
        next_divr = divider_value_register;
        next_swlsb = swallow_lsb_flag;
        next_unlock = unlock_flag;
        next_div_cnt = div_cnt;
        next_ref_cnt = ref_cnt;
        next_vco_d = vco_sel;
        next_ref_out = 1'b0;
        next_div_out = 1'b0;
        next_up = up_req;
        next_dn = dn_req;
        next_rdata = rdata;
        if (bus.wr) begin
            case (bus.addr)
                `PSC_ADDR_MODE: next_mode = bus.wdata[3:0];
                `PSC_ADDR_REFSEL: next_refsel = bus.wdata[3:0];
                `PSC_ADDR_DIVR: begin
                    next_divr = bus.wdata;
                    next_swlsb = mode[`PSC_SWLSB_BIT];
                end
                default: next_divr = divider_value_register;
            endcase
        end
        if (bus.rd) begin
            case (bus.addr)
                `PSC_ADDR_MODE: next_rdata = mode;
                `PSC_ADDR_REFSEL: next_rdata = refsel;
                `PSC_ADDR_LOCK: next_rdata = {3'b000, unlock_flag};
                default: next_rdata = 4'h0;
            endcase
        end
        if (state == psc_pkg::PSC_FULL_OFF) begin
            next_div_cnt = '0;
            next_ref_cnt = 16'd0;
            next_up = 1'b0;
            next_dn = 1'b0;
        end else begin
            if (xtal_tick) begin
                next_ref_cnt = (ref_cnt == 16'd0) ? ref_div - 16'd1 : ref_cnt - 16'd1;
            end
            if (div_pulse) begin
                // Reload with N so that a pulse falls every N input edges
                next_div_cnt = (div_cnt <= NW'(1)) ? n_val : div_cnt - NW'(1);
                next_div_out = (div_cnt <= NW'(1));
            end
            next_ref_out = ref_pulse;
            // Phase detector: each edge raises its side, a pair cancels
            if (ref_pulse && !next_div_out) begin
                next_up = dn_req ? 1'b0 : 1'b1;
                next_dn = 1'b0;
            end else if (next_div_out && !ref_pulse) begin
                next_dn = up_req ? 1'b0 : 1'b1;
                next_up = 1'b0;
            end else if (ref_pulse && next_div_out) begin
                next_up = 1'b0;
                next_dn = 1'b0;
            end
        end
        if (bus.rd && bus.addr == `PSC_ADDR_LOCK) begin
            next_unlock = 1'b0;
        end
        if (ref_pulse && (up_req || dn_req)) begin
            next_unlock = 1'b1;
        end
        if (watchdog_stack_reset || clock_stop_exec) begin
            next_refsel = `PSC_REF_DISABLE;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            mode <= `PSC_MODE_RST;
            refsel <= `PSC_REF_DISABLE;
            divider_value_register <= `PSC_DIVR_RST;
            swallow_lsb_flag <= 1'b0;
            unlock_flag <= 1'b0;
            div_cnt <= '0;
            ref_cnt <= 16'd0;
            vco_d <= 1'b0;
            ref_out <= 1'b0;
            div_out <= 1'b0;
            up_req <= 1'b0;
            dn_req <= 1'b0;
            rdata <= 4'h0;
        end else if (clk_en) begin
            // Chip enable low stops the loop but keeps registers
            mode <= next_mode;
            refsel <= next_refsel;
            divider_value_register <= next_divr;
            swallow_lsb_flag <= next_swlsb;
            unlock_flag <= next_unlock;
            div_cnt <= next_div_cnt;
            ref_cnt <= next_ref_cnt;
            vco_d <= next_vco_d;
            ref_out <= next_ref_out;
            div_out <= next_div_out;
            up_req <= next_up;
            dn_req <= next_dn;
            rdata <= next_rdata;
        end
    end

    // Charge pump: up drives low, down drives high, idle floats
    always_comb begin
        error_out_high.out = dn_req;
        error_out_low.out = dn_req;
        error_out_high.oe = (state != psc_pkg::PSC_FULL_OFF) && (up_req || dn_req);
        error_out_low.oe = error_out_high.oe;
    end

    chk_full_off_float: assert property (@(posedge core_clk) disable iff (!rst_n)
        (state == psc_pkg::PSC_FULL_OFF) |-> !error_out_high.oe && !error_out_low.oe)
        else $error("error outputs driven while disabled");
    chk_ce_low_off: assert property (@(posedge core_clk) disable iff (!rst_n)
        !chip_enable |-> low_band_vco_pulldown && high_band_vco_pulldown && !ref_pulse)
        else $error("synthesizer active with chip enable low");
    chk_ref_disable: assert property (@(posedge core_clk) disable iff (!rst_n)
        (refsel == `PSC_REF_DISABLE) |-> state == psc_pkg::PSC_FULL_OFF)
        else $error("reference code 1111 did not disable");
    chk_vco_off_run: assert property (@(posedge core_clk) disable iff (!rst_n)
        (chip_enable && div_mode(mode) == `PSC_MODE_OFF && refsel < `PSC_REF_BAD0) |->
        low_band_vco_pulldown && high_band_vco_pulldown && state == psc_pkg::PSC_VCO_OFF)
        else $error("mode zero did not isolate only the inputs");
    chk_lock_read: assert property (@(posedge core_clk) disable iff (!rst_n || !clk_en)
        (bus.rd && bus.addr == `PSC_ADDR_LOCK) |=> rdata[3:1] == 3'b000
        && rdata[0] == $past(unlock_flag))
        else $error("lock status read wrong");
    chk_read_clear: assert property (@(posedge core_clk) disable iff (!rst_n || !clk_en)
        (bus.rd && bus.addr == `PSC_ADDR_LOCK && !(ref_pulse && (up_req || dn_req)))
        |=> !unlock_flag)
        else $error("unlock flag not cleared by read");
    chk_wdt_refsel: assert property (@(posedge core_clk) disable iff (!rst_n || !clk_en)
        (watchdog_stack_reset || clock_stop_exec) |=> refsel == `PSC_REF_DISABLE)
        else $error("reset event did not disable reference");
    chk_lsb_capture: assert property (@(posedge core_clk) disable iff (!rst_n || !clk_en)
        (bus.wr && bus.addr == `PSC_ADDR_DIVR) |=>
        swallow_lsb_flag == $past(mode[`PSC_SWLSB_BIT]))
        else $error("swallow lsb not captured on data write");
    chk_high_band: assert property (@(posedge core_clk) disable iff (!rst_n)
        (state == psc_pkg::PSC_RUN && div_mode(mode) == `PSC_MODE_SW_HIGH) |->
        low_band_vco_pulldown && !high_band_vco_pulldown)
        else $error("high band input not selected");
    chk_halt_keep: assert property (@(posedge core_clk) disable iff (!rst_n || !clk_en)
        (halt_state && chip_enable && !bus.wr && !watchdog_stack_reset && !clock_stop_exec)
        |=> mode == $past(mode) && refsel == $past(refsel))
        else $error("halt changed synthesizer settings");
endmodule

// ### bench/psc_vco_model.sv
`timescale 1ns/100ps
module psc_vco_model (
    input wire logic core_clk,
    input wire logic run,
    input wire logic [3:0] half,
    input wire psc_pkg::psc_pin_s error_out_high,
    output logic vco,
    output logic tune_up
);
    int cnt = 0;
    initial vco = 1'b0;
    // Oscillator rests low while stopped
    always @(posedge core_clk) begin
        if (!run) begin
            vco <= #1 1'b0;
            cnt <= 0;
        end else if (cnt + 1 >= int'(half)) begin
            vco <= #1 ~vco;
            cnt <= 0;
        end else begin
            cnt <= cnt + 1;
        end
    end
    // Loop filter: driven low pushes tuning up
    assign tune_up = error_out_high.oe & ~error_out_high.out;
endmodule

// ### bench/tb_top.sv
`timescale 1ns/100ps
`include "psc_defs.svh"
module tb_top;
    logic core_clk = 1'b0, rst_n = 1'b0, chip_enable = 1'b1, wsr = 1'b0, cse = 1'b0;
    logic halt_state = 1'b0, xtal_tick = 1'b0, run = 1'b0, lo_on = 1'b0, hi_on = 1'b0;
    logic clk_en = 1'b1;
    logic vco, tune_up, lo_pd, hi_pd, ref_out, div_out;
    logic [3:0] rdata;
    logic [31:0] seed = 32'd78159;
    psc_pkg::psc_bus_s bus = '0;
    psc_pkg::psc_pin_s eoh, eol;
    int errors = 0, num_checks = 0, xc = 0;
    always #20 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        xc <= (xc == 4) ? 0 : xc + 1;
        xtal_tick <= #1 (xc == 0);
    end
    psc_synth_ctrl psc_synth_ctrl_i (.core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en),
        .chip_enable(chip_enable), .watchdog_stack_reset(wsr), .clock_stop_exec(cse),
        .halt_state(halt_state), .xtal_tick(xtal_tick), .bus(bus), .rdata(rdata),
        .low_band_vco_input(vco & lo_on), .high_band_vco_input(vco & hi_on),
        .low_band_vco_pulldown(lo_pd), .high_band_vco_pulldown(hi_pd),
        .error_out_high(eoh), .error_out_low(eol), .ref_out(ref_out), .div_out(div_out));
    psc_vco_model psc_vco_model_i (.core_clk(core_clk), .run(run), .half(4'h2),
        .error_out_high(eoh), .vco(vco), .tune_up(tune_up));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [1:0] pd_exp(input logic [1:0] m);
        return (m == 2'h0) ? 2'b11 : (m == 2'h3) ? 2'b10 : 2'b01;
    endfunction
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic close_out();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge core_clk);
        #1 bus = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge core_clk);
        #1 bus = '0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [3:0] q);
        @(posedge core_clk);
        #1 bus = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
        @(posedge core_clk);
        #1 bus = '0;
        @(posedge core_clk);
        #1 q = rdata;
    endtask
    task automatic pulse(ref logic s);
        @(posedge core_clk);
        #1 s = 1'b1;
        @(posedge core_clk);
        #1 s = 1'b0;
    endtask
    task automatic quiet(input string name);
        logic seen;
        seen = 1'b0;
        repeat (3) @(posedge core_clk);
        repeat (600) begin
            @(negedge core_clk);
            seen |= ref_out | div_out | eoh.oe | eol.oe | ~lo_pd | ~hi_pd;
        end
        check(name, 16'(seen), 16'h0);
    endtask
    initial begin
        int i, k, edges, pulses, refs;
        logic [3:0] q, m;
        logic [16:0] n;
        logic pv;
        repeat (8) @(posedge core_clk);
        #1 rst_n = 1'b1;
        rd(`PSC_ADDR_LOCK, q);
        check("lock after reset", 16'(q), 16'h0);
        quiet("off after power-on");
        $display("test power_on done");
        wr(`PSC_ADDR_REFSEL, 16'h0007);
        for (i = 0; i < 3000 && eoh.oe !== 1'b1; i++) @(negedge core_clk);
        if (i == 3000) begin
            errors++;
            close_out();
        end
        check("error pins", 16'({eoh.oe, eoh.out, eol.oe, eol.out}), 16'ha);
        check("tune", 16'(tune_up), 16'h1);
        check("pulldowns", 16'({lo_pd, hi_pd}), 16'h3);
        // One reference period: flag sets at the next reference edge
        refs = 0;
        repeat (452) begin
            @(negedge core_clk);
            refs += int'(ref_out);
        end
        check("ref pulses", 16'(refs), 16'h1);
        rd(`PSC_ADDR_LOCK, q);
        check("lock unlocked", 16'(q), 16'h1);
        rd(8'h30, q);
        check("unmapped read", 16'(q), 16'h0);
        $display("test vco_off done");
        for (k = 1; k < 4; k++) begin
            seed = lfsr(seed);
            n = 17'(8 + seed[2:0]);
            lo_on = (k != 3);
            hi_on = (k == 3);
            m = (k == 1) ? 4'h1 : {n[0], 1'b0, 2'(k)};
            wr(`PSC_ADDR_MODE, {12'h000, m});
            wr(`PSC_ADDR_DIVR, (k == 1) ? {n[11:0], 4'h0} : n[16:1]);
            check("pulldowns", 16'({lo_pd, hi_pd}), 16'(pd_exp(2'(k))));
            run = 1'b1;
            repeat (40) @(posedge core_clk);
            edges = 0;
            pulses = 0;
            pv = vco;
            repeat (480) begin
                @(negedge core_clk);
                edges += int'(vco & ~pv);
                pv = vco;
                pulses += int'(div_out);
            end
            check("div ratio", 16'(pulses * n >= edges - n && pulses * n <= edges + n),
                16'h1);
        end
        $display("test division done");
        @(posedge core_clk);
        #1 chip_enable = 1'b0;
        quiet("off while chip disabled");
        @(posedge core_clk);
        #1 chip_enable = 1'b1;
        repeat (3) @(posedge core_clk);
        #1 check("settings restored", 16'({lo_pd, hi_pd}), 16'h2);
        halt_state = 1'b1;
        repeat (50) @(posedge core_clk);
        #1 check("halt keeps mode", 16'({lo_pd, hi_pd}), 16'h2);
        halt_state = 1'b0;
        // Write while frozen must not land
        clk_en = 1'b0;
        wr(`PSC_ADDR_MODE, 16'h0000);
        clk_en = 1'b1;
        repeat (2) @(posedge core_clk);
        #1 check("frozen write", 16'({lo_pd, hi_pd}), 16'h2);
        $display("test chip_enable done");
        for (k = 0; k < 5; k++) begin
            case (k)
                0: wr(`PSC_ADDR_REFSEL, {12'h000, `PSC_REF_DISABLE});
                1: wr(`PSC_ADDR_REFSEL, {12'h000, `PSC_REF_BAD0});
                2: wr(`PSC_ADDR_REFSEL, {12'h000, `PSC_REF_BAD1});
                3: pulse(wsr);
                default: pulse(cse);
            endcase
            quiet("disable source");
            wr(`PSC_ADDR_REFSEL, 16'h0007);
            repeat (2) @(posedge core_clk);
            #1 check("enable again", 16'({lo_pd, hi_pd}), 16'h2);
        end
        $display("test disables done");
        close_out();
    end
endmodule
